// ===== rtl/abu_ctrl.sv
// Autobuffer control bits of the serial extension control register
`timescale 1ns/100ps
`default_nettype none
`include "abu_defines.svh"

module autobuf_ctrl
	import halfbuf_pkg::*;
#(
	parameter int FIFO_DEPTH = `RX_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [15:0] cpu_wdata,
	output logic [15:0] cpu_rdata,
	output logic [`SP_CTRL_MSB:0] sp_ctrl,
	output logic rx_autobuf_enable,
	output logic tx_autobuf_enable,
	input wire logic [`BLOCK_SIZE_WIDTH-1:0] rx_block_size,
	input wire logic [`BLOCK_SIZE_WIDTH-1:0] tx_block_size,
	input wire logic sp_rx_valid,
	input wire logic [`WORD_WIDTH-1:0] sp_rx_data,
	output logic sp_rx_ready,
	output logic mem_wr_valid,
	output logic [`WORD_WIDTH-1:0] mem_wr_data,
	input wire logic mem_wr_ready,
	input wire logic sp_tx_req,
	output logic tx_fetch,
	input wire logic mem_rd_valid,
	input wire logic [`WORD_WIDTH-1:0] mem_rd_data,
	output logic sp_tx_valid,
	output logic [`WORD_WIDTH-1:0] sp_tx_data,
	input wire logic sp_rx_word_int,
	input wire logic sp_tx_word_int,
	output logic receive_interrupt,
	output logic transmit_interrupt
);
	logic rx_auto_halt_r;
	logic rx_half_flag_r;
	logic rx_en_r;
	logic tx_auto_halt_r;
	logic tx_half_flag_r;
	logic tx_en_r;
	logic [`SP_CTRL_MSB:0] sp_ctrl_r;
	word_t ser_ext_control;
	word_t rdata_r;
	logic reg_hit;
	logic reg_wr;
	block_size_t rx_pos_r;
	block_size_t tx_pos_r;
	block_size_t rx_pos_inc;
	block_size_t tx_pos_inc;
	logic rx_done;
	cross_t rx_cross_first;
	cross_t rx_cross_second;
	cross_t tx_cross_first;
	cross_t tx_cross_second;
	logic rx_cross;
	logic tx_cross;
	logic rx_int_r;
	logic tx_int_r;
	logic tx_fetch_r;
	logic tx_valid_r;
	word_t tx_data_r;
	logic fifo_in_valid;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	assign reg_hit = cpu_addr == `SER_EXT_CTRL_ADDR;
	assign reg_wr = cpu_wr && reg_hit;
	assign ser_ext_control = {rx_auto_halt_r, rx_half_flag_r, rx_en_r,
		tx_auto_halt_r, tx_half_flag_r, tx_en_r, sp_ctrl_r};

	// Register bits
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sp_ctrl_r <= `SP_CTRL_WIDTH'(`SER_EXT_CTRL_RESET);
			rx_auto_halt_r <= 1'b0;
			tx_auto_halt_r <= 1'b0;
		end else if (reg_wr) begin
			sp_ctrl_r <= cpu_wdata[`SP_CTRL_MSB:0];
			rx_auto_halt_r <= cpu_wdata[`RX_AUTO_HALT_BIT];
			tx_auto_halt_r <= cpu_wdata[`TX_AUTO_HALT_BIT];
		end
	end

	// A software write in the boundary cycle beats the auto-halt clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_en_r <= 1'b0;
		end else if (reg_wr) begin
			rx_en_r <= cpu_wdata[`RX_AUTOBUF_ENABLE_BIT];
		end else if (rx_cross && rx_auto_halt_r) begin
			rx_en_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_en_r <= 1'b0;
		end else if (reg_wr) begin
			tx_en_r <= cpu_wdata[`TX_AUTOBUF_ENABLE_BIT];
		end else if (tx_cross && tx_auto_halt_r) begin
			tx_en_r <= 1'b0;
		end
	end

	// Half flags follow boundaries only; written values are dropped
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_half_flag_r <= 1'b0;
			tx_half_flag_r <= 1'b0;
		end else begin
			if (rx_cross_first == HALF_DONE) begin
				rx_half_flag_r <= 1'b0;
			end else if (rx_cross_second == HALF_DONE) begin
				rx_half_flag_r <= 1'b1;
			end
			if (tx_cross_first == HALF_DONE) begin
				tx_half_flag_r <= 1'b0;
			end else if (tx_cross_second == HALF_DONE) begin
				tx_half_flag_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= (cpu_rd && reg_hit) ? ser_ext_control : '0;
		end
	end

	// Receive path: port words queue here, so a stalled memory stalls the port
	assign fifo_in_valid = sp_rx_valid && rx_en_r;

	word_fifo #(
		.WIDTH(`WORD_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) rx_fifo (
		.clk(clk),
		.arst_n(arst_n),
		.in_valid(fifo_in_valid),
		.in_data(sp_rx_data),
		.in_ready(sp_rx_ready),
		.out_valid(mem_wr_valid),
		.out_data(mem_wr_data),
		.out_ready(mem_wr_ready)
	);

	// Words already queued at a halt still land; the boundary counts writes
	assign rx_done = mem_wr_valid && mem_wr_ready;
	assign rx_pos_inc = rx_pos_r + 1'b1;
	assign tx_pos_inc = tx_pos_r + 1'b1;

	always_comb begin
		rx_cross_first = HALF_NONE;
		rx_cross_second = HALF_NONE;
		if (rx_done && rx_pos_inc == (rx_block_size >> 1)) begin
			rx_cross_first = HALF_DONE;
		end else if (rx_done && rx_pos_inc == rx_block_size) begin
			rx_cross_second = HALF_DONE;
		end
	end

	always_comb begin
		tx_cross_first = HALF_NONE;
		tx_cross_second = HALF_NONE;
		if (mem_rd_valid && tx_pos_inc == (tx_block_size >> 1)) begin
			tx_cross_first = HALF_DONE;
		end else if (mem_rd_valid && tx_pos_inc == tx_block_size) begin
			tx_cross_second = HALF_DONE;
		end
	end

	assign rx_cross = rx_cross_first == HALF_DONE ||
		rx_cross_second == HALF_DONE;
	assign tx_cross = tx_cross_first == HALF_DONE ||
		tx_cross_second == HALF_DONE;

	// Enabling restarts the count at the top of the buffer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_pos_r <= '0;
		end else if (reg_wr && !rx_en_r &&
			cpu_wdata[`RX_AUTOBUF_ENABLE_BIT]) begin
			rx_pos_r <= '0;
		end else if (rx_cross_second == HALF_DONE) begin
			rx_pos_r <= '0;
		end else if (rx_done) begin
			rx_pos_r <= rx_pos_inc;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_pos_r <= '0;
		end else if (reg_wr && !tx_en_r &&
			cpu_wdata[`TX_AUTOBUF_ENABLE_BIT]) begin
			tx_pos_r <= '0;
		end else if (tx_cross_second == HALF_DONE) begin
			tx_pos_r <= '0;
		end else if (mem_rd_valid) begin
			tx_pos_r <= tx_pos_inc;
		end
	end

	// Transmit path: one fetch per port request, word handed on a cycle later
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_fetch_r <= 1'b0;
			tx_valid_r <= 1'b0;
			tx_data_r <= '0;
		end else begin
			tx_fetch_r <= sp_tx_req && tx_en_r;
			tx_valid_r <= mem_rd_valid;
			if (mem_rd_valid) begin
				tx_data_r <= mem_rd_data;
			end
		end
	end

	// Per-word port interrupts pass only in standard mode
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_int_r <= 1'b0;
			tx_int_r <= 1'b0;
		end else begin
			rx_int_r <= rx_en_r ? rx_cross : sp_rx_word_int;
			tx_int_r <= tx_en_r ? tx_cross : sp_tx_word_int;
		end
	end

	assign cpu_rdata = rdata_r;
	assign sp_ctrl = sp_ctrl_r;
	assign rx_autobuf_enable = rx_en_r;
	assign tx_autobuf_enable = tx_en_r;
	assign tx_fetch = tx_fetch_r;
	assign sp_tx_valid = tx_valid_r;
	assign sp_tx_data = tx_data_r;
	assign receive_interrupt = rx_int_r;
	assign transmit_interrupt = tx_int_r;

	// Software may enable again right after the halt, so only a write excuses it
	rx_halt_clear_a: assert property (
		rx_cross && rx_auto_halt_r && !reg_wr |=>
		!rx_en_r ##1 (!rx_en_r || $past(reg_wr)))
		else $error("receive enable survived an auto-halt boundary");
	rx_half_track_a: assert property (
		rx_cross_second == HALF_DONE |=>
		rx_half_flag_r && (receive_interrupt || !$past(rx_en_r)))
		else $error("receive half flag not set after second half");
	rx_enable_write_a: assert property (
		reg_wr |=> rx_en_r == $past(cpu_wdata[`RX_AUTOBUF_ENABLE_BIT]))
		else $error("receive enable did not take the written value");
	tx_halt_clear_a: assert property (
		tx_cross && tx_auto_halt_r && !reg_wr |=> !tx_en_r)
		else $error("transmit enable survived an auto-halt boundary");
	tx_half_track_a: assert property (
		tx_cross_first == HALF_DONE |=> !tx_half_flag_r)
		else $error("transmit half flag not cleared after first half");
	tx_enable_write_a: assert property (
		reg_wr && cpu_wdata[`TX_AUTOBUF_ENABLE_BIT] |=> tx_en_r)
		else $error("transmit enable not set by a write");
	sp_ctrl_keep_a: assert property (
		!reg_wr |=> $stable(sp_ctrl))
		else $error("serial port control bits changed without a write");
	rx_word_int_a: assert property (
		rx_en_r && !rx_cross |=> !receive_interrupt)
		else $error("per-word receive interrupt in autobuffer mode");
	tx_word_int_a: assert property (
		tx_en_r && !tx_cross |=> !transmit_interrupt)
		else $error("per-word transmit interrupt in autobuffer mode");
	reset_value_a: assert property (
		$rose(arst_n) |-> ser_ext_control == `SER_EXT_CTRL_RESET)
		else $error("extension register not 3 after reset");
	half_flag_ro_a: assert property (
		reg_wr && !rx_cross && !tx_cross |=>
		$stable(rx_half_flag_r) && $stable(tx_half_flag_r))
		else $error("half flag changed by a software write");

	rx_boundary_c: cover property (rx_en_r && rx_cross);
	rx_autohalt_c: cover property (rx_en_r && rx_cross && rx_auto_halt_r);
	tx_wrap_c: cover property (tx_en_r && tx_cross_second == HALF_DONE);
	fifo_full_c: cover property (rx_en_r && !sp_rx_ready ##1 sp_rx_ready);
endmodule
`default_nettype wire

// ===== rtl/abu_defines.svh
// Constants for the autobuffer control bits and their data paths
`ifndef AUTOBUF_DEFINES_SVH
`define AUTOBUF_DEFINES_SVH
`define SER_EXT_CTRL_ADDR 16'h0033
`define SER_EXT_CTRL_RESET 16'h0003
`define SER_EXT_CTRL_WR_MASK 16'hb7ff
`define RX_AUTO_HALT_BIT 15
`define RX_HALF_FLAG_BIT 14
`define RX_AUTOBUF_ENABLE_BIT 13
`define TX_AUTO_HALT_BIT 12
`define TX_HALF_FLAG_BIT 11
`define TX_AUTOBUF_ENABLE_BIT 10
`define SP_CTRL_MSB 9
`define SP_CTRL_WIDTH 10
`define BLOCK_SIZE_WIDTH 11
`define WORD_WIDTH 16
`define RX_FIFO_DEPTH 4
`endif

// ===== rtl/abu_fifo.sv
// Shift-register FIFO between the serial port and the buffer memory
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [CW-1:0] count_r;
	logic [CW-1:0] count_nxt;
	logic [CW-1:0] wr_idx;
	logic push;
	logic pop;

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	// Head always sits in entry 0, so read data comes straight from a flop
	assign out_data = mem_r[0];
	assign wr_idx = pop ? count_r - 1'b1 : count_r;

	always_comb begin
		count_nxt = count_r;
		if (push && !pop) begin
			count_nxt = count_r + 1'b1;
		end else if (pop && !push) begin
			count_nxt = count_r - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_r <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			count_r <= count_nxt;
			in_ready <= count_nxt != CW'(DEPTH);
			out_valid <= count_nxt != '0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				if (push && wr_idx == CW'(i)) begin
					mem_r[i] <= in_data;
				end else if (pop && i < DEPTH - 1) begin
					mem_r[i] <= mem_r[(i + 1) % DEPTH];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== rtl/abu_pkg.sv
// Types shared by the autobuffer control files
package halfbuf_pkg;
	typedef logic [15:0] word_t;
	typedef logic [10:0] block_size_t;
	typedef enum logic {HALF_NONE, HALF_DONE} cross_t;
endpackage

// ===== test/autobuffer_control_bits_bench.sv
// Self-checking bench for the autobuffer control bits block
`timescale 1ns/100ps
`default_nettype none
`include "abu_defines.svh"
module autobuffer_control_bits_bench
	import halfbuf_pkg::*;
;
	logic clk, arst_n, cpu_wr, cpu_rd, sp_rx_valid, mem_wr_ready, sp_tx_req;
	logic mem_rd_valid, sp_rx_word_int, sp_tx_word_int;
	logic [15:0] cpu_addr, cpu_wdata, sp_rx_data, mem_rd_data;
	wire logic [15:0] cpu_rdata, mem_wr_data, sp_tx_data;
	wire logic [9:0] sp_ctrl;
	wire logic rx_autobuf_enable, tx_autobuf_enable, sp_rx_ready;
	wire logic mem_wr_valid, tx_fetch, sp_tx_valid;
	wire logic receive_interrupt, transmit_interrupt;
	int error_cnt = 0;
	int comparisons = 0;
	int rx_ic, tx_ic, nw;
	logic [15:0] exp_d, r, nxt_d;

	autobuf_ctrl #(.FIFO_DEPTH(4)) dut_u (.clk(clk), .arst_n(arst_n),
		.cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
		.cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .sp_ctrl(sp_ctrl),
		.rx_autobuf_enable(rx_autobuf_enable),
		.tx_autobuf_enable(tx_autobuf_enable),
		.rx_block_size(11'h004), .tx_block_size(11'h004),
		.sp_rx_valid(sp_rx_valid), .sp_rx_data(sp_rx_data),
		.sp_rx_ready(sp_rx_ready), .mem_wr_valid(mem_wr_valid),
		.mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready),
		.sp_tx_req(sp_tx_req), .tx_fetch(tx_fetch),
		.mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
		.sp_tx_valid(sp_tx_valid), .sp_tx_data(sp_tx_data),
		.sp_rx_word_int(sp_rx_word_int), .sp_tx_word_int(sp_tx_word_int),
		.receive_interrupt(receive_interrupt),
		.transmit_interrupt(transmit_interrupt));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic stop_test();
		if (error_cnt == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Steps n cycles; callers drive just after the falling edge where it stops
	task automatic cyc(input int n);
		repeat (n) begin
			// The head seen now is what the coming rising edge pops
			if (mem_wr_valid === 1'b1 && mem_wr_ready) begin
				chk(mem_wr_data, exp_d);
				exp_d++;
				nw++;
			end
			@(negedge clk);
			if (receive_interrupt === 1'b1) rx_ic++;
			if (transmit_interrupt === 1'b1) tx_ic++;
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr = 1'b1;
		cyc(1);
		cpu_wr = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		cpu_addr = a;
		cpu_rd = 1'b1;
		cyc(1);
		cpu_rd = 1'b0;
		d = cpu_rdata;
		cyc(1);
	endtask

	// A word counts only if the block can take it at the coming edge
	task automatic rx_word();
		logic acc;
		acc = sp_rx_ready === 1'b1 && rx_autobuf_enable === 1'b1;
		sp_rx_valid = 1'b1;
		sp_rx_data = nxt_d;
		cyc(1);
		sp_rx_valid = 1'b0;
		sp_rx_data = ~nxt_d;
		if (acc) nxt_d++;
		cyc(1);
	endtask

	task automatic tx_word(input logic [15:0] d, input logic en);
		sp_tx_req = 1'b1;
		cyc(1);
		sp_tx_req = 1'b0;
		chk(tx_fetch, en);
		if (en) begin
			mem_rd_valid = 1'b1;
			mem_rd_data = d;
			cyc(1);
			mem_rd_valid = 1'b0;
			mem_rd_data = ~d;
			chk(sp_tx_valid, 1'b1);
			chk(sp_tx_data, d);
		end
	endtask

	task automatic t_regs();
		rd(`SER_EXT_CTRL_ADDR, r);
		chk(r, 16'h0003);
		chk(sp_ctrl, 10'h003);
		chk({rx_autobuf_enable, tx_autobuf_enable}, 2'h0);
		wr(`SER_EXT_CTRL_ADDR, 16'hffff);
		rd(`SER_EXT_CTRL_ADDR, r);
		chk(r, 16'hb7ff);
		chk(sp_ctrl, 10'h3ff);
		// Writes elsewhere must leave the register alone and read back zero
		wr(16'h0034, 16'h0000);
		rd(16'h0034, r);
		chk(r, 16'h0000);
		rd(`SER_EXT_CTRL_ADDR, r);
		chk(r, 16'hb7ff);
		wr(`SER_EXT_CTRL_ADDR, 16'h0003);
	endtask

	task automatic t_word_int(input logic on);
		rx_ic = 0;
		tx_ic = 0;
		sp_rx_word_int = 1'b1;
		sp_tx_word_int = 1'b1;
		cyc(1);
		sp_rx_word_int = 1'b0;
		sp_tx_word_int = 1'b0;
		cyc(2);
		chk(rx_ic, !on);
		chk(tx_ic, !on);
	endtask

	task automatic t_rx();
		rx_ic = 0;
		repeat (2) rx_word();
		cyc(3);
		chk(rx_ic, 1);
		rd(`SER_EXT_CTRL_ADDR, r);
		chk(r[14], 1'b0);
		repeat (2) rx_word();
		cyc(3);
		rd(`SER_EXT_CTRL_ADDR, r);
		chk(r[14], 1'b1);
		chk(rx_ic, 2);
		// Memory stalls: four words fill the queue and a fifth is refused
		mem_wr_ready = 1'b0;
		repeat (5) rx_word();
		cyc(1);
		chk(sp_rx_ready, 1'b0);
		mem_wr_ready = 1'b1;
		cyc(8);
		chk(nw, 8);
		chk(rx_ic, 4);
		wr(`SER_EXT_CTRL_ADDR, 16'ha403);
		repeat (2) rx_word();
		cyc(3);
		chk(rx_autobuf_enable, 1'b0);
		chk(sp_ctrl, 10'h003);
		rd(`SER_EXT_CTRL_ADDR, r);
		chk(r[14], 1'b0);
		rx_word();
		cyc(3);
		chk(nw, 10);
	endtask

	task automatic t_tx();
		tx_ic = 0;
		tx_word(16'h5a01, 1'b1);
		tx_word(16'h5a02, 1'b1);
		chk(tx_ic, 1);
		rd(`SER_EXT_CTRL_ADDR, r);
		chk(r[11], 1'b0);
		tx_word(16'h5a03, 1'b1);
		tx_word(16'h5a04, 1'b1);
		rd(`SER_EXT_CTRL_ADDR, r);
		chk(r[11], 1'b1);
		// Writing 0 to bit 11 must leave the set flag alone
		wr(`SER_EXT_CTRL_ADDR, 16'h1403);
		rd(`SER_EXT_CTRL_ADDR, r);
		chk(r[11], 1'b1);
		tx_word(16'h5a05, 1'b1);
		tx_word(16'h5a06, 1'b1);
		cyc(1);
		chk(tx_autobuf_enable, 1'b0);
		chk(tx_ic, 3);
		tx_word(16'h5a07, 1'b0);
	endtask

	initial begin
		{cpu_wr, cpu_rd, sp_rx_valid, sp_tx_req, mem_rd_valid} = 5'h00;
		{sp_rx_word_int, sp_tx_word_int} = 2'h0;
		mem_wr_ready = 1'b1;
		cpu_addr = 16'h0000;
		cpu_wdata = 16'h0000;
		sp_rx_data = 16'h0000;
		mem_rd_data = 16'h0000;
		exp_d = 16'h0000;
		nxt_d = 16'h0000;
		nw = 0;
		arst_n = 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		t_regs();
		t_word_int(1'b0);
		wr(`SER_EXT_CTRL_ADDR, 16'h2403);
		t_word_int(1'b1);
		t_rx();
		t_tx();
		stop_test();
	end

	// Whole run needs under a hundred cycles; this leaves wide margin
	initial begin
		#20000;
		error_cnt++;
		stop_test();
	end
endmodule
`default_nettype wire
